// *** tb/bcdadj_unit_properties.sv ***
// checker: port properties of the decimal-adjust unit
// assumes it is bound onto bcdadj_unit
`timescale 1ns/100ps
module bcdadj_checker (
  input wire logic       i_sys_clk, i_reset_n, i_decimal_adjust_instr,
  input wire logic       i_acc_wr, o_busy, o_done, o_carry_flag,
  input wire logic       o_digit_carry_flag, o_zero_flag, o_overflow_flag,
  input wire logic       o_negative_flag, o_lo_corrected, o_hi_corrected,
  input wire logic [7:0] i_acc_wdata, o_acc
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic       lf, hf;
  logic [4:0] ls, hb, hs;
  logic [8:0] ex;
  wire  logic iss = i_decimal_adjust_instr && !o_busy;
  // expected result from the accumulator as it stands
  always_comb begin
    lf = o_acc[3:0] > 4'h9 || o_digit_carry_flag;
    ls = {1'b0, o_acc[3:0]} + (lf ? 5'h06 : 5'h00);
    hb = {1'b0, o_acc[7:4]} + {4'h0, ls[4]};
    hf = hb > 5'h09 || o_carry_flag;
    hs = hb + (hf ? 5'h06 : 5'h00);
    ex = {hs[4] | o_carry_flag, hs[3:0], ls[3:0]};
  end
  busy_window_a: assert property (iss |=> o_busy[*4] ##1 !o_busy)
    else $error("busy window");
  done_delay_a: assert property (iss |=> !o_done[*3] ##1 o_done)
    else $error("done delay");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done pulse");
  low_fix_a: assert property (o_done |=> o_lo_corrected == $past(lf))
    else $error("low fix");
  high_fix_a: assert property (o_done |=> o_hi_corrected == $past(hf))
    else $error("high fix");
  result_value_a: assert property (
    o_done |=> {o_carry_flag, o_acc} == $past(ex)) else $error("result");
  flags_kept_a: assert property (o_done |=> $stable({o_digit_carry_flag,
    o_zero_flag, o_overflow_flag, o_negative_flag})) else $error("flags");
  acc_hold_a: assert property (o_busy && !o_done |=> $stable(o_acc))
    else $error("acc hold");
  acc_load_a: assert property (
    i_acc_wr && !o_busy |=> o_acc == $past(i_acc_wdata)) else $error("load");
  cover property (iss);
  cover property (o_done && lf);
  cover property (o_done && hf);
endmodule
bind bcdadj_unit bcdadj_checker u_chk (.*);

// *** tb/testbench.sv ***
// testbench: corner and random decimal adjusts on bcdadj_unit
// assumes a 200 MHz clock and synchronous active-low reset
`timescale 1ns/100ps
module testbench;
  logic       i_sys_clk = 0, i_reset_n = 0, i_decimal_adjust_instr = 0;
  logic       i_acc_wr = 0, i_flag_wr = 0;
  logic [7:0] i_acc_wdata = 8'h00;
  logic [4:0] i_flag_wdata = 5'h00;
  logic       o_busy, o_done, o_carry_flag, o_digit_carry_flag;
  logic       o_zero_flag, o_overflow_flag, o_negative_flag;
  logic       o_lo_corrected, o_hi_corrected;
  logic [7:0] o_acc;
  int         errors = 0, check_count = 0;
  bcdadj_unit uut (.*);
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  // {low fixed, high fixed, carry, acc}
  function automatic logic [10:0] model(input logic [7:0] a, input logic [4:0] f);
    logic [4:0] l, h;
    logic       lf, hf;
    lf = a[3:0] > 4'h9 || f[1];
    l = {1'b0, a[3:0]} + (lf ? 5'h06 : 5'h00);
    h = {1'b0, a[7:4]} + {4'h0, l[4]};
    hf = h > 5'h09 || f[0];
    h = h + (hf ? 5'h06 : 5'h00);
    return {lf, hf, h[4] | f[0], h[3:0], l[3:0]};
  endfunction
  task automatic check(input string n, input logic [10:0] e, input logic [10:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // every register back at its reset value, sequencer idle
  task automatic check_cleared();
    check("reset", 11'h000, {o_busy, o_done, o_carry_flag, o_acc});
    check("reset flags", 11'h000, {5'h00, o_lo_corrected,
      o_hi_corrected, o_negative_flag, o_overflow_flag, o_zero_flag,
      o_digit_carry_flag});
  endtask
  task automatic adjust(input logic [7:0] a, input logic [4:0] f);
    int n;
    n = 0;
    i_acc_wr = 1;
    i_flag_wr = 1;
    i_acc_wdata = a;
    i_flag_wdata = f;
    @(posedge i_sys_clk) #1;
    i_acc_wr = 0;
    i_flag_wr = 0;
    i_decimal_adjust_instr = 1;
    @(posedge i_sys_clk) #1;
    // loads and a repeated issue while busy must be ignored
    i_acc_wr = 1;
    i_flag_wr = 1;
    i_acc_wdata = ~a;
    i_flag_wdata = ~f;
    @(posedge i_sys_clk) #1;
    i_decimal_adjust_instr = 0;
    i_acc_wr = 0;
    i_flag_wr = 0;
    while (o_done !== 1'b1 && n < 8) begin
      @(posedge i_sys_clk) #1;
      n++;
    end
    if (o_done !== 1'b1) begin
      errors++;
      complete_run();
    end
    @(posedge i_sys_clk) #1;
    check("result", model(a, f), {o_lo_corrected, o_hi_corrected,
      o_carry_flag, o_acc});
    check("flags", {7'h00, f[4:1]}, {7'h00, o_negative_flag,
      o_overflow_flag, o_zero_flag, o_digit_carry_flag});
    check("busy", 11'h000, {10'h000, o_busy});
  endtask
  initial begin
    logic [7:0] corner [6];
    corner = '{8'hA5, 8'hCE, 8'h99, 8'h9A, 8'hFF, 8'h00};
    void'($urandom(32'h3A8F4F86));
    repeat (8) @(posedge i_sys_clk);
    #1 i_reset_n = 1;
    @(posedge i_sys_clk) #1;
    check_cleared();
    foreach (corner[k]) for (int c = 0; c < 4; c++) adjust(corner[k], c[4:0]);
    // reset in mid-adjust abandons it and clears every register
    i_acc_wr = 1;
    i_flag_wr = 1;
    i_acc_wdata = 8'h9A;
    i_flag_wdata = 5'h1F;
    i_decimal_adjust_instr = 1;
    @(posedge i_sys_clk) #1;
    i_acc_wr = 0;
    i_flag_wr = 0;
    i_decimal_adjust_instr = 0;
    @(posedge i_sys_clk) #1;
    check("busy", 11'h001, {10'h000, o_busy});
    check("load", 11'h09A, {3'h0, o_acc});
    i_reset_n = 0;
    repeat (2) @(posedge i_sys_clk);
    #1 i_reset_n = 1;
    @(posedge i_sys_clk) #1;
    check_cleared();
    repeat (300) adjust(8'($urandom), 5'($urandom));
    complete_run();
  end
endmodule

// *** verilog/bcdadj_nibble_fix.sv ***
// single-digit decimal correction, purely combinational
// assumes the caller registers the digit and carry it produces
`timescale 1ns/100ps
module bcdadj_nibble_fix (
  // digit in
  input  wire logic [3:0] i_digit,
  input  wire logic       i_carry_in,
  input  wire logic       i_force,
  // digit out
  output logic      [3:0] o_digit,
  output logic            o_carry,
  output logic            o_corrected
);

  logic [4:0] sum_in;
  logic [4:0] total;

  always_comb begin
    sum_in      = {1'b0, i_digit} + {4'h0, i_carry_in};
    o_corrected = i_force | bcdadj_pkg::bcdadj_digit_over(sum_in);
    if (o_corrected) begin
      total = sum_in + {1'b0, bcdadj_pkg::BCD_CORRECTION};
    end else begin
      total = sum_in;
    end
    o_digit = total[3:0];
    o_carry = total[4];
  end

endmodule

// *** verilog/bcdadj_pkg.sv ***
// package: constants, states and helpers of the decimal-adjust unit
// assumes one 200 MHz core clock and a synchronous active-low reset
// Functional notes
// RULE1: low nibble above 9 or digit carry set adds 6, else unchanged.
// RULE2: high nibble plus carry-in above 9 or carry set adds 6 plus carry-in.
// RULE3: works on the whole 8-bit accumulator, yields a valid packed-BCD byte; a forced fix of a digit sum of 4 to 9 gives a digit above 9.
// RULE4: operand read only from accumulator, result written only to accumulator.
// RULE5: carry set on high correction overflow or prior carry; other flags kept.
package bcdadj_pkg;

  // datapath widths
  localparam int unsigned ACC_W   = 8;
  localparam int unsigned NIB_W   = 4;
  localparam int unsigned FLAG_W  = 5;

  // decimal correction constants
  localparam logic [3:0] BCD_MAX_DIGIT  = 4'h9;
  localparam logic [3:0] BCD_CORRECTION = 4'h6;

  // status flag bit positions
  localparam int unsigned FLAG_CARRY_BIT    = 0;
  localparam int unsigned FLAG_DIGIT_BIT    = 1;
  localparam int unsigned FLAG_ZERO_BIT     = 2;
  localparam int unsigned FLAG_OVERFLOW_BIT = 3;
  localparam int unsigned FLAG_NEGATIVE_BIT = 4;

  // reset values
  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic [4:0] FLAG_RESET = 5'h00;

  // instruction cycle sequencer, one state per quarter cycle
  typedef enum logic [2:0] {
    BCDADJ_IDLE    = 3'b000,
    BCDADJ_DECODE  = 3'b001,
    BCDADJ_READ    = 3'b010,
    BCDADJ_PROCESS = 3'b011,
    BCDADJ_WRITE   = 3'b100
  } bcdadj_state_t;

  // true when a digit sum (with carry-in) is past the decimal range
  function automatic logic bcdadj_digit_over(input logic [4:0] sum);
    bcdadj_digit_over = (sum > {1'b0, BCD_MAX_DIGIT});
  endfunction

endpackage

// *** verilog/bcdadj_unit.sv ***
// decimal-adjust unit: accumulator, status flags and a four-phase
// instruction sequencer that corrects the accumulator to packed BCD
// assumes the decoder pulses the issue strobe only while not busy and
// that all inputs come from logic on the core clock
`timescale 1ns/100ps
module bcdadj_unit (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  // decoder issue
  input  wire logic       i_decimal_adjust_instr,
  // core accumulator load
  input  wire logic       i_acc_wr,
  input  wire logic [7:0] i_acc_wdata,
  // core status load
  input  wire logic       i_flag_wr,
  input  wire logic [4:0] i_flag_wdata,
  // sequencer status
  output logic            o_busy,
  output logic            o_done,
  // accumulator and flags
  output logic      [7:0] o_acc,
  output logic            o_carry_flag,
  output logic            o_digit_carry_flag,
  output logic            o_zero_flag,
  output logic            o_overflow_flag,
  output logic            o_negative_flag,
  // last correction applied
  output logic            o_lo_corrected,
  output logic            o_hi_corrected
);

  bcdadj_pkg::bcdadj_state_t state;
  bcdadj_pkg::bcdadj_state_t next_state;

  logic [7:0] acc;
  logic [4:0] flags;

  // operand snapshot taken in the read phase
  logic [7:0] operand;
  logic       operand_carry;
  logic       operand_digit;

  // corrected value held from process to write phase
  logic [7:0] result;
  logic       result_carry;
  logic       result_lo_fix;
  logic       result_hi_fix;

  // correction datapath
  logic [3:0] lo_digit;
  logic       lo_carry;
  logic       lo_fix;
  logic [3:0] hi_digit;
  logic       hi_carry;
  logic       hi_fix;

  logic       core_load_ok;

  // phase strobes decoded once from the sequencer state
  logic       phase_idle;
  logic       phase_read;
  logic       phase_process;
  logic       phase_write;
  logic       issue_take;

  // true while the sequencer sits in the given phase
  function automatic logic in_phase(
    input bcdadj_pkg::bcdadj_state_t now,
    input bcdadj_pkg::bcdadj_state_t want
  );
    in_phase = (now == want);
  endfunction

  assign phase_idle    = in_phase(state, bcdadj_pkg::BCDADJ_IDLE);
  assign phase_read    = in_phase(state, bcdadj_pkg::BCDADJ_READ);
  assign phase_process = in_phase(state, bcdadj_pkg::BCDADJ_PROCESS);
  assign phase_write   = in_phase(state, bcdadj_pkg::BCDADJ_WRITE);
  // a new adjust is taken only from idle, repeats while busy are dropped
  assign issue_take    = phase_idle && i_decimal_adjust_instr;

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      bcdadj_pkg::BCDADJ_IDLE: begin
        if (issue_take) begin
          next_state = bcdadj_pkg::BCDADJ_DECODE;
        end
      end
      bcdadj_pkg::BCDADJ_DECODE: begin
        next_state = bcdadj_pkg::BCDADJ_READ;
      end
      bcdadj_pkg::BCDADJ_READ: begin
        next_state = bcdadj_pkg::BCDADJ_PROCESS;
      end
      bcdadj_pkg::BCDADJ_PROCESS: begin
        next_state = bcdadj_pkg::BCDADJ_WRITE;
      end
      bcdadj_pkg::BCDADJ_WRITE: begin
        next_state = bcdadj_pkg::BCDADJ_IDLE;
      end
      default: begin
        next_state = bcdadj_pkg::BCDADJ_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state <= bcdadj_pkg::BCDADJ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // core loads are held off while an adjust owns the accumulator
  assign core_load_ok = phase_idle;

  // read phase: operand comes from the accumulator alone
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      operand <= bcdadj_pkg::ACC_RESET;
    end else if (phase_read) begin
      operand <= acc; // RULE4
    end
  end

  // read phase: carry and digit carry captured with the operand
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      operand_carry <= 1'b0;
      operand_digit <= 1'b0;
    end else if (phase_read) begin
      operand_carry <= flags[bcdadj_pkg::FLAG_CARRY_BIT];
      operand_digit <= flags[bcdadj_pkg::FLAG_DIGIT_BIT];
    end
  end

  // low digit: forced by digit carry, else only when above nine
  bcdadj_nibble_fix u_lo_fix (
    .i_digit     (operand[3:0]),
    .i_carry_in  (1'b0),
    .i_force     (operand_digit),
    .o_digit     (lo_digit),
    .o_carry     (lo_carry),
    .o_corrected (lo_fix)
  ); // RULE1

  // high digit: takes the low correction carry, forced by carry flag
  bcdadj_nibble_fix u_hi_fix (
    .i_digit     (operand[7:4]),
    .i_carry_in  (lo_carry),
    .i_force     (operand_carry),
    .o_digit     (hi_digit),
    .o_carry     (hi_carry),
    .o_corrected (hi_fix)
  ); // RULE2

  // process phase: whole byte corrected as one value
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      result       <= bcdadj_pkg::ACC_RESET;
      result_carry <= 1'b0;
    end else if (phase_process) begin
      result       <= {hi_digit, lo_digit}; // RULE3
      result_carry <= hi_carry | operand_carry; // RULE5
    end
  end

  // process phase: which digits needed a correction
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      result_lo_fix <= 1'b0;
      result_hi_fix <= 1'b0;
    end else if (phase_process) begin
      result_lo_fix <= lo_fix;
      result_hi_fix <= hi_fix;
    end
  end

  // accumulator: write phase wins, core loads only when idle
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      acc <= bcdadj_pkg::ACC_RESET;
    end else if (phase_write) begin
      acc <= result; // RULE4
    end else if (core_load_ok && i_acc_wr) begin
      acc <= i_acc_wdata;
    end
  end

  // status flags: adjust touches carry only
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      flags <= bcdadj_pkg::FLAG_RESET;
    end else if (phase_write) begin
      flags[bcdadj_pkg::FLAG_CARRY_BIT] <= result_carry; // RULE5
    end else if (core_load_ok && i_flag_wr) begin
      flags <= i_flag_wdata;
    end
  end

  // record of the last correction, updated with the write-back
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_lo_corrected <= 1'b0;
      o_hi_corrected <= 1'b0;
    end else if (phase_write) begin
      o_lo_corrected <= result_lo_fix;
      o_hi_corrected <= result_hi_fix;
    end
  end

  // outputs
  assign o_busy             = !phase_idle;
  assign o_done             = phase_write;
  assign o_acc              = acc;
  assign o_carry_flag       = flags[bcdadj_pkg::FLAG_CARRY_BIT];
  assign o_digit_carry_flag = flags[bcdadj_pkg::FLAG_DIGIT_BIT];
  assign o_zero_flag        = flags[bcdadj_pkg::FLAG_ZERO_BIT];
  assign o_overflow_flag    = flags[bcdadj_pkg::FLAG_OVERFLOW_BIT];
  assign o_negative_flag    = flags[bcdadj_pkg::FLAG_NEGATIVE_BIT];

endmodule
